/* File: pfs_pin_function_selector.v */
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pfs_defs.vh"

module pfs_pin_function_selector (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped
  input wire [7:0] port1_pin_in, // port 1 pad levels
  output reg [7:0] port1_pin_out, // port 1 pad output value
  output reg [7:0] port1_pin_oe, // port 1 pad drive enable
  output reg [7:0] port1_pin_pu, // port 1 pull-up enable
  input wire [7:0] port3_pin_in, // port 3 pad levels
  output reg [7:0] port3_pin_out, // port 3 pad output value
  output reg [7:0] port3_pin_oe, // port 3 pad drive enable
  output reg [7:0] port3_pin_pu, // port 3 pull-up enable
  input wire reset_pin_in, // reset pad level
  input wire uart_a_take, // first uart enabled
  input wire uart_a_txd, // first uart transmit
  input wire uart_b_take, // second uart enabled
  input wire uart_b_txd, // second uart transmit
  input wire pwm_a_take, // first pwm enabled
  input wire pwm_a_out, // first pwm level
  input wire pwm_b_take, // second pwm enabled
  input wire pwm_b_out, // second pwm level
  input wire spi_take, // spi enabled
  input wire spi_master, // spi is master
  input wire spi_mosi_out, // master data out
  input wire spi_miso_out, // slave data out
  input wire spi_sck_out, // master clock out
  input wire timer_c_count_take, // timer-c count input used
  input wire capture_a_take, // capture a used
  input wire timer_c_ext_take, // timer-c ext input used
  input wire capture_b_take, // capture b used
  input wire timer_a_count_take, // timer-a count input used
  input wire ext_interrupt_a_take, // ext interrupt a used
  input wire [5:0] touch_take, // touch channels used
  input wire [1:0] typec_detect_take, // type-c detect used
  input wire [1:0] bus_voltage_detect_take, // bus detect used
  input wire [3:0] analog_take, // analog inputs used
  input wire crystal_take, // crystal oscillator on
  input wire reset_pin_take, // reset function on pad
  input wire usb_dp_out, // usb d+ value
  input wire usb_dp_oe, // usb d+ drive enable
  input wire usb_dm_out, // usb d- value
  input wire usb_dm_oe, // usb d- drive enable
  input wire gpio_irq_level, // gpio valid level present
  input wire gpio_irq_edge, // gpio valid edge pulse
  input wire gpio_irq_ack, // gpio irq service entry
  output reg uart_a_rxd, // first uart receive
  output reg uart_b_rxd, // second uart receive
  output reg spi_mosi_in, // spi slave data in
  output reg spi_miso_in, // spi master data in
  output reg spi_sck_in, // spi slave clock in
  output reg spi_chip_select, // spi slave select in
  output reg timer_c_count_input, // timer-c count input
  output reg capture_input_a, // capture a input
  output reg timer_c_ext_input, // timer-c ext input
  output reg capture_input_b, // capture b input
  output reg timer_a_count_input, // timer-a count input
  output reg ext_interrupt_a, // ext interrupt a input
  output reg usb_dp_in, // usb d+ level
  output reg usb_dm_in, // usb d- level
  output reg pin_reset_req, // reset request from pad
  output reg gpio_irq_active // gpio irq activity flag
);

  reg [7:0] port1_data_q;
  reg [7:0] port1_mode_q;
  reg [7:0] port1_dirpu_q;
  reg [7:0] port3_data_q;
  reg [7:0] port3_mode_q;
  reg [7:0] port3_dirpu_q;
  reg [7:0] pin_function_select_q;
  reg edge_mode_q;
  reg [7:0] p1_meta_q;
  reg [7:0] p1_sync_q;
  reg [7:0] p3_meta_q;
  reg [7:0] p3_sync_q;
  reg rst_meta_q;
  reg rst_sync_q;
  reg [2:0] d1 [0:7];
  reg [2:0] d3 [0:7];
  reg [7:0] rd_d;
  reg hit_d;
  integer i;
  integer j;

  wire usb_take = pin_function_select_q[`PFS_BIT_USB_TAKE];
  wire ub_r = pin_function_select_q[`PFS_BIT_UART_B];
  wire ua_r = pin_function_select_q[`PFS_BIT_UART_A];
  wire pb_r = pin_function_select_q[`PFS_BIT_PWM_B];
  wire pa_r = pin_function_select_q[`PFS_BIT_PWM_A];
  wire te_r = pin_function_select_q[`PFS_BIT_TC_EXT];
  wire tc_r = pin_function_select_q[`PFS_BIT_TC_CNT];

  // claims after remap selection
  wire tc_home = (timer_c_count_take | capture_a_take) & ~tc_r;
  wire tc_alt = (timer_c_count_take | capture_a_take) & tc_r;
  wire te_home = (timer_c_ext_take | capture_b_take) & ~te_r;
  wire ua_home = uart_a_take & ~ua_r;
  wire ua_alt = uart_a_take & ua_r;
  wire ub_home = uart_b_take & ~ub_r;
  wire ub_alt = uart_b_take & ub_r;
  wire pa_home = pwm_a_take & ~pa_r;
  wire pa_alt = pwm_a_take & pa_r;
  wire pb_home = pwm_b_take & ~pb_r;
  wire pb_alt = pwm_b_take & pb_r;

  wire apb_access = psel & penable;
  wire aligned = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
  wire [7:0] idx = paddr[9:2];

  // gpio pad control from mode pair
  function [2:0] gpio_drv(input mo, input dp, input v);
    begin
      case ({mo, dp})
        2'h0: gpio_drv = `PFS_DRV_ANA; // high-z input, no pull-up
        2'h1: gpio_drv = {v, 1'b1, 1'b0}; // push-pull
        2'h2: gpio_drv = {1'b0, ~v, 1'b0}; // open drain
        default: gpio_drv = {1'b0, ~v, 1'b1}; // quasi, pull-up
      endcase
    end
  endfunction

  // module drives the pad
  function [2:0] out_drv(input v);
    begin
      out_drv = {v, 1'b1, 1'b0};
    end
  endfunction

  // pad control: gpio first, then claims from lowest to highest rank;
  // the last assignment wins so each pin's order reads bottom-up
  always @*
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      d1[i] = gpio_drv(port1_mode_q[i], port1_dirpu_q[i],
                       port1_data_q[i]);
      d3[i] = gpio_drv(port3_mode_q[i], port3_dirpu_q[i],
                       port3_data_q[i]);
    end
    // port 1 pin 0: touch, capture a, timer-c count
    if (touch_take[0])
      d1[0] = `PFS_DRV_ANA;
    if (tc_home)
      d1[0] = `PFS_DRV_IN;
    // port 1 pin 1: analog group, then timer-c ext/capture b
    if (touch_take[1] | bus_voltage_detect_take[1] | analog_take[0])
      d1[1] = `PFS_DRV_ANA;
    if (te_home)
      d1[1] = `PFS_DRV_IN;
    // port 1 pins 2/3: remapped first uart under crystal
    if (ua_alt)
      d1[2] = `PFS_DRV_IN;
    if (ua_alt)
      d1[3] = out_drv(uart_a_txd);
    if (crystal_take)
      d1[2] = `PFS_DRV_ANA;
    if (crystal_take)
      d1[3] = `PFS_DRV_ANA;
    // port 1 pin 4
    if (touch_take[2] | typec_detect_take[0] | analog_take[1])
      d1[4] = `PFS_DRV_ANA;
    if (spi_take & ~spi_master)
      d1[4] = `PFS_DRV_IN;
    if (tc_alt)
      d1[4] = `PFS_DRV_IN;
    // port 1 pin 5
    if (touch_take[3] | typec_detect_take[1] | analog_take[2])
      d1[5] = `PFS_DRV_ANA;
    if (pa_home)
      d1[5] = out_drv(pwm_a_out);
    if (spi_take)
      d1[5] = spi_master ? out_drv(spi_mosi_out) : `PFS_DRV_IN;
    // port 1 pins 6/7: touch, second uart, spi
    if (touch_take[4])
      d1[6] = `PFS_DRV_ANA;
    if (touch_take[5])
      d1[7] = `PFS_DRV_ANA;
    if (ub_home)
      d1[6] = `PFS_DRV_IN;
    if (ub_home)
      d1[7] = out_drv(uart_b_txd);
    if (spi_take)
      d1[6] = spi_master ? `PFS_DRV_IN : out_drv(spi_miso_out);
    if (spi_take)
      d1[7] = spi_master ? out_drv(spi_sck_out) : `PFS_DRV_IN;
    // port 3 pins 0/1: first uart under remapped pwm
    if (ua_home)
      d3[0] = `PFS_DRV_IN;
    if (ua_home)
      d3[1] = out_drv(uart_a_txd);
    if (pa_alt)
      d3[0] = out_drv(pwm_a_out);
    if (pb_alt)
      d3[1] = out_drv(pwm_b_out);
    // port 3 pin 2
    if (bus_voltage_detect_take[0] | analog_take[3])
      d3[2] = `PFS_DRV_ANA;
    if (ext_interrupt_a_take)
      d3[2] = `PFS_DRV_IN;
    if (ub_alt)
      d3[2] = out_drv(uart_b_txd);
    // port 3 pin 4
    if (timer_a_count_take | ub_alt)
      d3[4] = `PFS_DRV_IN;
    if (pb_home)
      d3[4] = out_drv(pwm_b_out);
    // usb pads ignore port mode settings while taken
    if (usb_take)
      d3[6] = {usb_dp_out, usb_dp_oe, 1'b0};
    if (usb_take)
      d3[7] = {usb_dm_out, usb_dm_oe, 1'b0};
  end

  // register read mux; unmapped or misaligned gives an error
  always @*
  begin
    hit_d = aligned;
    rd_d = 8'h00;
    case (idx)
      `PFS_IDX_PORT1_DATA: rd_d = p1_sync_q;
      `PFS_IDX_PORT1_MODE: rd_d = port1_mode_q;
      `PFS_IDX_PORT1_DIRPU: rd_d = port1_dirpu_q;
      `PFS_IDX_PORT3_DATA: rd_d = p3_sync_q;
      `PFS_IDX_PORT3_MODE: rd_d = port3_mode_q;
      `PFS_IDX_PORT3_DIRPU: rd_d = port3_dirpu_q;
      `PFS_IDX_FUNC_SEL:
      begin
        rd_d = pin_function_select_q;
        rd_d[`PFS_BIT_IRQ_ACT] = gpio_irq_active;
      end
      `PFS_IDX_IRQ_MODE: rd_d = {7'h00, edge_mode_q};
      default: hit_d = 1'b0;
    endcase
  end

  // apb slave: one wait cycle, write lands on the completing edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      port1_data_q <= `PFS_RST_PORT;
      port1_mode_q <= `PFS_RST_PORT;
      port1_dirpu_q <= `PFS_RST_PORT;
      port3_data_q <= `PFS_RST_PORT;
      port3_mode_q <= `PFS_RST_PORT;
      port3_dirpu_q <= `PFS_RST_PORT;
      pin_function_select_q <= `PFS_RST_FUNC_SEL;
      edge_mode_q <= 1'b0;
    end
    else
    begin
      if (apb_access & ~pready)
      begin
        pready <= 1'b1;
        prdata <= {24'h000000, rd_d};
        pslverr <= ~hit_d;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      if (apb_access & pready & pwrite & hit_d)
      begin
        case (idx)
          `PFS_IDX_PORT1_DATA: port1_data_q <= pwdata[7:0];
          `PFS_IDX_PORT1_MODE: port1_mode_q <= pwdata[7:0];
          `PFS_IDX_PORT1_DIRPU: port1_dirpu_q <= pwdata[7:0];
          `PFS_IDX_PORT3_DATA: port3_data_q <= pwdata[7:0];
          `PFS_IDX_PORT3_MODE: port3_mode_q <= pwdata[7:0];
          `PFS_IDX_PORT3_DIRPU: port3_dirpu_q <= pwdata[7:0];
          // activity bit is read-only; writes to it are dropped
          `PFS_IDX_FUNC_SEL:
            pin_function_select_q <= pwdata[7:0] & 8'hBF;
          `PFS_IDX_IRQ_MODE: edge_mode_q <= pwdata[`PFS_BIT_EDGE_MODE];
          default: edge_mode_q <= edge_mode_q;
        endcase
      end
    end
  end

  // two-flop synchronisers for pad levels
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p1_meta_q <= 8'hFF;
      p1_sync_q <= 8'hFF;
      p3_meta_q <= 8'hFF;
      p3_sync_q <= 8'hFF;
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      p1_meta_q <= port1_pin_in;
      p1_sync_q <= p1_meta_q;
      p3_meta_q <= port3_pin_in;
      p3_sync_q <= p3_meta_q;
      rst_meta_q <= reset_pin_in;
      rst_sync_q <= rst_meta_q;
    end
  end

  // activity flag: level mode follows, edge mode is sticky and the
  // new edge beats a same-cycle service entry so none is lost
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gpio_irq_active <= 1'b0;
    else if (!edge_mode_q)
      gpio_irq_active <= gpio_irq_level;
    else if (gpio_irq_edge)
      gpio_irq_active <= 1'b1;
    else if (gpio_irq_ack)
      gpio_irq_active <= 1'b0;
  end

  // registered pad and module-input outputs; a module input reads
  // its pad only when taken and not beaten, otherwise idles high; the usb levels and the reset request idle low
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port1_pin_out <= 8'h00;
      port1_pin_oe <= 8'h00;
      port1_pin_pu <= 8'h00;
      port3_pin_out <= 8'h00;
      port3_pin_oe <= 8'h00;
      port3_pin_pu <= 8'h00;
      uart_a_rxd <= 1'b1;
      uart_b_rxd <= 1'b1;
      spi_mosi_in <= 1'b1;
      spi_miso_in <= 1'b1;
      spi_sck_in <= 1'b1;
      spi_chip_select <= 1'b1;
      timer_c_count_input <= 1'b1;
      capture_input_a <= 1'b1;
      timer_c_ext_input <= 1'b1;
      capture_input_b <= 1'b1;
      timer_a_count_input <= 1'b1;
      ext_interrupt_a <= 1'b1;
      usb_dp_in <= 1'b0;
      usb_dm_in <= 1'b0;
      pin_reset_req <= 1'b0;
    end
    else
    begin
      for (j = 0; j < 8; j = j + 1)
      begin
        {port1_pin_out[j], port1_pin_oe[j], port1_pin_pu[j]} <= d1[j];
        {port3_pin_out[j], port3_pin_oe[j], port3_pin_pu[j]} <= d3[j];
      end
      uart_a_rxd <= ua_alt ? (crystal_take | p1_sync_q[2]) :
        (~ua_home | pa_alt | p3_sync_q[0]);
      uart_b_rxd <= ub_alt ? (pb_home | p3_sync_q[4]) :
        (~ub_home | spi_take | p1_sync_q[6]);
      spi_mosi_in <= ~spi_take | spi_master | p1_sync_q[5];
      spi_miso_in <= ~spi_take | ~spi_master | p1_sync_q[6];
      spi_sck_in <= ~spi_take | spi_master | p1_sync_q[7];
      spi_chip_select <= ~spi_take | spi_master | tc_alt |
        p1_sync_q[4];
      timer_c_count_input <= ~timer_c_count_take |
        (tc_r ? p1_sync_q[4] : p1_sync_q[0]);
      capture_input_a <= ~capture_a_take |
        (tc_r ? p1_sync_q[4] : p1_sync_q[0]);
      timer_c_ext_input <= ~timer_c_ext_take | (te_r ?
        (reset_pin_take | rst_sync_q) : p1_sync_q[1]);
      capture_input_b <= ~capture_b_take | (te_r ?
        (reset_pin_take | rst_sync_q) : p1_sync_q[1]);
      timer_a_count_input <= ~timer_a_count_take | pb_home | ub_alt |
        p3_sync_q[4];
      ext_interrupt_a <= ~ext_interrupt_a_take | ub_alt |
        p3_sync_q[2];
      usb_dp_in <= usb_take & p3_sync_q[6];
      usb_dm_in <= usb_take & p3_sync_q[7];
      pin_reset_req <= reset_pin_take & rst_sync_q;
    end
  end

endmodule
`default_nettype wire

/* File: pfs_defs.vh */
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH
// register indices; the byte address is four times the index
`define PFS_IDX_PORT1_DATA 8'h90
`define PFS_IDX_PORT1_MODE 8'h92
`define PFS_IDX_PORT1_DIRPU 8'h93
`define PFS_IDX_PORT3_DATA 8'hB0
`define PFS_IDX_PORT3_MODE 8'h96
`define PFS_IDX_PORT3_DIRPU 8'h97
`define PFS_IDX_FUNC_SEL 8'hC6
`define PFS_IDX_IRQ_MODE 8'hC7
// reset values
`define PFS_RST_PORT 8'hFF
`define PFS_RST_FUNC_SEL 8'h80
`define PFS_RST_IRQ_MODE 8'h00
// pin_function_select fields
`define PFS_BIT_USB_TAKE 7
`define PFS_BIT_IRQ_ACT 6
`define PFS_BIT_UART_B 5
`define PFS_BIT_UART_A 4
`define PFS_BIT_PWM_B 3
`define PFS_BIT_PWM_A 2
`define PFS_BIT_TC_EXT 1
`define PFS_BIT_TC_CNT 0
// irq mode register field
`define PFS_BIT_EDGE_MODE 0
// pin drive codes {out, oe, pullup}
`define PFS_DRV_ANA 3'h0
`define PFS_DRV_IN 3'h1
`endif

/* File: pfs_pin_checker_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module pfs_pin_checker (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [31:0] prdata, // apb read data
  input wire logic [7:0] port1_pin_out, // port 1 pad value
  input wire logic [7:0] port1_pin_oe, // port 1 drive enable
  input wire logic [7:0] port1_pin_pu, // port 1 pull-up
  input wire logic spi_take, // spi enabled
  input wire logic spi_master, // spi is master
  input wire logic spi_mosi_out, // master data out
  input wire logic spi_sck_out, // master clock out
  input wire logic crystal_take, // crystal on
  input wire logic reset_pin_take, // reset function on pad
  input wire logic pin_reset_req, // reset request
  input wire logic gpio_irq_level, // valid level
  input wire logic gpio_irq_edge, // valid edge pulse
  input wire logic gpio_irq_ack, // service entry
  input wire logic gpio_irq_active // activity flag
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bus answers exactly one cycle after the access is taken
  apb_answer_slot_a:
    assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after access");
  ready_one_cycle_a:
    assert property (pready |=> !pready)
    else $error("ready held too long");
  error_with_ready_a:
    assert property (pslverr |-> pready && prdata[31:8] == 24'h000000)
    else $error("error or upper data outside answer");
  // spi master outputs outrank every other claim on their pins
  mosi_pin_owner_a:
    assert property (spi_take && spi_master |=> port1_pin_oe[5]
      && port1_pin_out[5] == $past(spi_mosi_out))
    else $error("mosi not on its pad");
  sck_pin_owner_a:
    assert property (spi_take && spi_master |=> port1_pin_oe[7]
      && port1_pin_out[7] == $past(spi_sck_out))
    else $error("spi clock not on its pad");
  crystal_pins_free_a:
    assert property (crystal_take |=> !port1_pin_oe[2] && !port1_pin_oe[3]
      && !port1_pin_pu[2])
    else $error("crystal pads driven");
  reset_req_cause_a:
    assert property (pin_reset_req |-> $past(reset_pin_take))
    else $error("reset request without reset function");
  // flag set by edge with level, cleared by ack with no cause left
  irq_flag_set_a:
    assert property (gpio_irq_edge && gpio_irq_level |=> gpio_irq_active)
    else $error("activity flag not set");
  irq_flag_clear_a:
    assert property (gpio_irq_ack && !gpio_irq_edge && !gpio_irq_level
      |=> !gpio_irq_active)
    else $error("activity flag not cleared");
  irq_flag_cause_a:
    assert property ($rose(gpio_irq_active) |->
      $past(gpio_irq_edge) || $past(gpio_irq_level))
    else $error("activity flag rose without cause");
endmodule

bind pfs_pin_function_selector pfs_pin_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .port1_pin_out(port1_pin_out), .port1_pin_oe(port1_pin_oe),
  .port1_pin_pu(port1_pin_pu), .spi_take(spi_take),
  .spi_master(spi_master), .spi_mosi_out(spi_mosi_out),
  .spi_sck_out(spi_sck_out), .crystal_take(crystal_take),
  .reset_pin_take(reset_pin_take), .pin_reset_req(pin_reset_req),
  .gpio_irq_level(gpio_irq_level), .gpio_irq_edge(gpio_irq_edge),
  .gpio_irq_ack(gpio_irq_ack), .gpio_irq_active(gpio_irq_active));
`default_nettype wire

/* File: pin_function_selector_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pfs_defs.vh"
module pin_function_selector_bench;
  localparam logic [11:0] A_PF = {2'h0, `PFS_IDX_FUNC_SEL, 2'h0};
  localparam logic [11:0] A_IRQ = {2'h0, `PFS_IDX_IRQ_MODE, 2'h0};
  localparam logic [11:0] A_P1M = {2'h0, `PFS_IDX_PORT1_MODE, 2'h0};
  localparam logic [11:0] A_P1P = {2'h0, `PFS_IDX_PORT1_DIRPU, 2'h0};
  localparam logic [11:0] A_P1D = {2'h0, `PFS_IDX_PORT1_DATA, 2'h0};
  localparam logic [11:0] A_P3M = {2'h0, `PFS_IDX_PORT3_MODE, 2'h0};
  localparam logic [11:0] A_P3P = {2'h0, `PFS_IDX_PORT3_DIRPU, 2'h0};
  localparam logic [11:0] A_P3D = {2'h0, `PFS_IDX_PORT3_DATA, 2'h0};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, reset_pin_in = 1'h1, spi_master = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [7:0] port1_pin_in = 8'hFF, port3_pin_in = 8'hFF;
  logic uart_a_take = 1'h0, uart_a_txd = 1'h0, uart_b_take = 1'h0;
  logic uart_b_txd = 1'h0, pwm_a_take = 1'h0, pwm_a_out = 1'h0;
  logic pwm_b_take = 1'h0, pwm_b_out = 1'h0, spi_take = 1'h0;
  logic spi_mosi_out = 1'h0, spi_miso_out = 1'h0, spi_sck_out = 1'h0;
  logic timer_c_count_take = 1'h0, capture_a_take = 1'h0, rerr;
  logic timer_c_ext_take = 1'h0, capture_b_take = 1'h0;
  logic timer_a_count_take = 1'h0, ext_interrupt_a_take = 1'h0;
  logic [5:0] touch_take = 6'h00;
  logic [1:0] typec_detect_take = 2'h0, bus_voltage_detect_take = 2'h0;
  logic [3:0] analog_take = 4'h0;
  logic crystal_take = 1'h0, reset_pin_take = 1'h0, usb_dp_out = 1'h0;
  logic usb_dp_oe = 1'h1, usb_dm_out = 1'h0, usb_dm_oe = 1'h0;
  logic gpio_irq_level = 1'h0, gpio_irq_edge = 1'h0, gpio_irq_ack = 1'h0;
  logic [47:0] seen;
  wire [31:0] prdata;
  wire pready, pslverr, uart_a_rxd, uart_b_rxd, spi_mosi_in, spi_miso_in;
  wire spi_sck_in, spi_chip_select, timer_c_count_input, capture_input_a;
  wire timer_c_ext_input, capture_input_b, timer_a_count_input;
  wire ext_interrupt_a, usb_dp_in, usb_dm_in, pin_reset_req, gpio_irq_active;
  wire [7:0] port1_pin_out, port1_pin_oe, port1_pin_pu;
  wire [7:0] port3_pin_out, port3_pin_oe, port3_pin_pu;
  int err_total = 0, samples_checked = 0;

  pfs_pin_function_selector i_dut (.*);

  always #20 pclk = ~pclk;

  task automatic close_out();
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [47:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is sampled high; one idle edge after
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (n >= 50) err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // gpio pad {out masked by oe, oe, pullup} from data, mode, dir bits
  function automatic logic [23:0] gexp(input logic [7:0] dt, md, dp);
    return {~md & dp & dt, (~md & dp) | (md & ~dt), md & dp};
  endfunction

  // uart, pwm, timer and usb routing with the uart, pwm, timer, capture and ext interrupt claims enabled
  function automatic logic [41:0] rexp(input logic [7:0] pf);
    logic [7:0] o1, e1, o3, e3;
    logic ra, rb, tc, te;
    {o1, e1, o3, e3} = 32'h0;
    tc = pf[0] ? port1_pin_in[4] : port1_pin_in[0];
    te = pf[1] ? reset_pin_in : port1_pin_in[1];
    ra = pf[4] ? port1_pin_in[2] : (pf[2] ? 1'h1 : port3_pin_in[0]);
    rb = pf[5] ? (pf[3] ? port3_pin_in[4] : 1'h1) : port1_pin_in[6];
    if (pf[4]) {e1[3], o1[3]} = {1'h1, uart_a_txd};
    else if (!pf[3]) {e3[1], o3[1]} = {1'h1, uart_a_txd};
    if (pf[5]) {e3[2], o3[2]} = {1'h1, uart_b_txd};
    else {e1[7], o1[7]} = {1'h1, uart_b_txd};
    if (pf[2]) {e3[0], o3[0]} = {1'h1, pwm_a_out};
    else {e1[5], o1[5]} = {1'h1, pwm_a_out};
    if (pf[3]) {e3[1], o3[1]} = {1'h1, pwm_b_out};
    else {e3[4], o3[4]} = {1'h1, pwm_b_out};
    if (pf[7])
      {e3[7:6], o3[7:6]} = {usb_dm_oe, usb_dp_oe, usb_dm_out, usb_dp_out};
    // blocked module inputs read high, the usb levels low
    return {o1 & e1, e1, o3 & e3, e3, ra, rb, tc, te, tc, te,
      pf[5] | ~pf[3] | port3_pin_in[4], pf[5] | port3_pin_in[2],
      pf[7] & port3_pin_in[6], pf[7] & port3_pin_in[7]};
  endfunction

  // watchdog sized well above the expected run of little more than a thousand cycles
  initial
  begin
    #2000000;
    err_total++;
    close_out();
  end

  initial
  begin
    logic [7:0] md, dp, dt, pf;
    void'($urandom(13903));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    // after reset every pad but the two top port 3 pins is gpio; usb owns those two
    seen = {port1_pin_oe, port3_pin_oe};
    check("reset oe", 16'h0040, seen);
    apb(1'h0, A_PF, 8'h00);
    check("pin_function_select reset", `PFS_RST_FUNC_SEL, rdat);
    apb(1'h0, A_P1M, 8'h00);
    check("mode reset", `PFS_RST_PORT, rdat);
    apb(1'h0, 12'h004, 8'h00);
    check("unmapped err", 1'h1, rerr);
    // random gpio modes on both ports with no module claims
    apb(1'h1, A_PF, 8'h00);
    repeat (8)
    begin
      md = 8'($urandom);
      dp = 8'($urandom);
      dt = 8'($urandom);
      apb(1'h1, A_P1M, md);
      apb(1'h1, A_P1P, dp);
      apb(1'h1, A_P1D, dt);
      apb(1'h1, A_P3M, ~md);
      apb(1'h1, A_P3P, dp);
      apb(1'h1, A_P3D, ~dt);
      repeat (2) @(posedge pclk);
      seen = {port1_pin_out & port1_pin_oe, port1_pin_oe, port1_pin_pu};
      check("port1 pads", gexp(dt, md, dp), seen);
      seen = {port3_pin_out & port3_pin_oe, port3_pin_oe, port3_pin_pu};
      check("port3 pads", gexp(~dt, ~md, dp), seen);
    end
    // all remap settings, gpio pads set to plain input
    {uart_a_take, uart_b_take, pwm_a_take, pwm_b_take} <= 4'hF;
    {timer_c_count_take, timer_c_ext_take, capture_a_take} <= 3'h7;
    {capture_b_take, timer_a_count_take, ext_interrupt_a_take} <= 3'h7;
    apb(1'h1, A_P1M, 8'h00);
    apb(1'h1, A_P1P, 8'h00);
    apb(1'h1, A_P3M, 8'h00);
    apb(1'h1, A_P3P, 8'h00);
    for (int i = 0; i < 128; i++)
    begin
      pf = {i[6], 1'h0, i[5:0]};
      {uart_a_txd, uart_b_txd, pwm_a_out, pwm_b_out} <= 4'($urandom);
      {usb_dp_out, usb_dp_oe, usb_dm_out, usb_dm_oe} <= 4'($urandom);
      {port1_pin_in, port3_pin_in} <= 16'($urandom);
      reset_pin_in <= 1'($urandom);
      apb(1'h1, A_PF, pf);
      repeat (3) @(posedge pclk);
      seen = {port1_pin_out & port1_pin_oe, port1_pin_oe,
        port3_pin_out & port3_pin_oe, port3_pin_oe, uart_a_rxd, uart_b_rxd,
        timer_c_count_input, timer_c_ext_input, capture_input_a,
        capture_input_b, timer_a_count_input, ext_interrupt_a, usb_dp_in,
        usb_dm_in};
      check("routing", rexp(pf),
        seen);
    end
    // spi master, crystal and reset function beat the lower claims
    {spi_take, spi_master, crystal_take, reset_pin_take} <= 4'hF;
    {spi_mosi_out, spi_sck_out, reset_pin_in} <= 3'h4;
    {port1_pin_in, port3_pin_in} <= 16'h0000;
    apb(1'h1, A_PF, 8'h12);
    repeat (3) @(posedge pclk);
    seen = {port1_pin_oe[5], port1_pin_out[5], port1_pin_oe[7], uart_b_rxd};
    check("spi pads", 4'hF, seen);
    check("crystal", 2'h1, {port1_pin_oe[3], uart_a_rxd});
    check("reset pad", 2'h2, {timer_c_ext_input, pin_reset_req});
    // spi slave reads its pads and drives miso over the second uart
    spi_master <= 1'h0;
    spi_miso_out <= 1'h1;
    port1_pin_in <= 8'($urandom);
    repeat (4) @(posedge pclk);
    seen = {spi_mosi_in, spi_sck_in, spi_chip_select, spi_miso_in,
      port1_pin_oe[6], port1_pin_out[6]};
    check("spi slave", {port1_pin_in[5], port1_pin_in[7], port1_pin_in[4],
      3'h7}, seen);
    apb(1'h0, A_P1D, 8'h00);
    check("pad read", port1_pin_in, rdat);
    {spi_take, crystal_take, reset_pin_take} <= 3'h0;
    // level mode follows the input, edge mode keeps the flag
    gpio_irq_level <= 1'h1;
    apb(1'h0, A_PF, 8'h00);
    check("irq level", 2'h3, {rdat[6], gpio_irq_active});
    gpio_irq_level <= 1'h0;
    apb(1'h1, A_IRQ, 8'h01);
    check("irq idle", 1'h0, gpio_irq_active);
    {gpio_irq_edge, gpio_irq_level} <= 2'h3;
    @(posedge pclk);
    {gpio_irq_edge, gpio_irq_level} <= 2'h0;
    apb(1'h1, A_PF, 8'h12);
    apb(1'h0, A_PF, 8'h00);
    check("irq sticky", 2'h3, {rdat[6], gpio_irq_active});
    // a new edge in the service-entry cycle must not be lost
    {gpio_irq_edge, gpio_irq_ack} <= 2'h3;
    @(posedge pclk);
    {gpio_irq_edge, gpio_irq_ack} <= 2'h0;
    @(posedge pclk);
    check("irq edge wins", 1'h1, gpio_irq_active);
    gpio_irq_ack <= 1'h1;
    @(posedge pclk);
    gpio_irq_ack <= 1'h0;
    repeat (2) @(posedge pclk);
    check("irq ack", 1'h0, gpio_irq_active);
    gpio_irq_edge <= 1'h1;
    @(posedge pclk);
    gpio_irq_edge <= 1'h0;
    apb(1'h1, A_IRQ, 8'h00);
    @(posedge pclk);
    check("irq to level", 1'h0, gpio_irq_active);
    close_out();
  end
endmodule
`default_nettype wire
